// >>> verilog/wake_map.svh
`ifndef WAKE_MAP_SVH
`define WAKE_MAP_SVH

`define WAKE_ADDR_W           8
`define WAKE_CTRL_OFFSET      8'h68
`define WAKE_PDATA_OFFSET     8'h70
`define WAKE_NUM_PATTERNS     5
`define WAKE_WORDS_PER_PAT    5
`define WAKE_TABLE_WORDS      25
`define WAKE_PTR_W            5
`define WAKE_PTR_LAST         5'h18
`define WAKE_MASK_BYTES       128
`define WAKE_BIT_CRC_SEL      30
`define WAKE_BIT_PAT1_EN      29
`define WAKE_BIT_PAT_WAKE_EN  10
`define WAKE_BIT_AR_WAKE_EN   9
`define WAKE_BIT_LC_WAKE_EN   8
`define WAKE_BIT_PAT_FLAG     2
`define WAKE_BIT_AR_FLAG      1
`define WAKE_BIT_LC_FLAG      0
`define WAKE_FLAGS_FIELD      2:0
`define WAKE_FIELD_CRC        31:16
`define WAKE_FIELD_START      7:0
`define WAKE_CRC_POLY         16'h8005
`define WAKE_CRC_PRESET_ZERO  16'h0000
`define WAKE_CRC_PRESET_ONES  16'hFFFF
`define WAKE_IDX_W            9

`endif

// >>> verilog/wake_pkg.sv
package wake_pkg;
`include "wake_map.svh"

    typedef logic [31:0] word_t;
    typedef logic [15:0] crc_t;
    typedef logic [7:0]  byte_t;
    typedef logic [`WAKE_ADDR_W-1:0] csr_addr_t;

    typedef struct packed {
        logic [`WAKE_IDX_W-1:0] idx;
        crc_t                   crc;
        logic                   match;
    } match_state_t;

    typedef struct packed {
        logic                                       link_meta;
        logic                                       link_sync;
        logic                                       link_prev;
        logic                                       crc_sel;
        logic [`WAKE_NUM_PATTERNS-1:0]              pat_en;
        logic                                       pat_wake_en;
        logic                                       ar_wake_en;
        logic                                       lc_wake_en;
        logic [2:0]                                 flags;
        logic [`WAKE_TABLE_WORDS-1:0][31:0]         table_q;
        logic [`WAKE_PTR_W-1:0]                     ptr;
        word_t                                      rdata;
        logic                                       pme;
    } wake_state_t;

endpackage

// >>> verilog/wake_pattern_matcher.sv
`timescale 1ns/1ps
`include "wake_map.svh"
module wake_pattern_matcher #(
    parameter int MASK_BYTES = `WAKE_MASK_BYTES
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_srst,
    input  wire logic [MASK_BYTES-1:0] i_mask,
    input  wire wake_pkg::crc_t        i_ref_crc,
    input  wire wake_pkg::byte_t       i_start_offset,
    input  wire logic                  i_preset_sel,
    input  wire logic                  i_enable,
    input  wire logic                  i_byte_valid,
    input  wire wake_pkg::byte_t       i_byte,
    input  wire logic                  i_frame_start,
    input  wire logic                  i_frame_end,
    output logic                       o_match
);
    import wake_pkg::*;

    match_state_t st;
    match_state_t next_st;

    function automatic crc_t crc_byte(input crc_t c, input byte_t b);
        crc_t r;
        r = c;
        for (int k = 7; k >= 0; k--) begin
            if (r[15] ^ b[k]) begin
                r = {r[14:0], 1'b0} ^ `WAKE_CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    logic [`WAKE_IDX_W-1:0] base_idx;
    crc_t                   base_crc;
    logic [`WAKE_IDX_W-1:0] rel;
    logic                   in_window;

    // see RL17 - crc over mask-selected bytes from the start offset
    always_comb begin
        next_st   = st;
        base_idx  = i_frame_start ? '0 : st.idx;
        base_crc  = i_frame_start ? (i_preset_sel ? `WAKE_CRC_PRESET_ONES
                                                  : `WAKE_CRC_PRESET_ZERO) : st.crc; // see RL13
        rel       = base_idx - {1'b0, i_start_offset};
        in_window = (base_idx >= {1'b0, i_start_offset}) && (rel < MASK_BYTES[`WAKE_IDX_W-1:0]);
        next_st.match = 1'b0;
        if (i_byte_valid) begin
            next_st.crc = base_crc;
            if (in_window && i_mask[rel[6:0]]) begin
                next_st.crc = crc_byte(base_crc, i_byte);
            end
            if (~&base_idx) begin
                next_st.idx = base_idx + 1'b1;
            end else begin
                next_st.idx = base_idx;
            end
        end
        if (i_frame_end) begin
            next_st.match = i_enable && (next_st.crc == i_ref_crc); // see RL14
        end
        if (i_srst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        st <= next_st;
    end

    assign o_match = st.match;
endmodule

// >>> verilog/wake_event_pattern_ctrl.sv
`timescale 1ns/1ps
`include "wake_map.svh"
// Overview of operation
// RL1 - address-repeat wake enable routes address-repeat frames to power event; config preset
// RL2 - link-change wake enable routes link changes to power event; resets to zero
// RL3 - matched wake-up pattern frame sets the pattern frame flag
// RL4 - received address-repeat wake frame sets the address-repeat flag
// RL5 - detected link status change sets the link-change flag
// RL6 - flags readable, cleared only by writing one or by power-up reset
// RL7 - flags keep their value through hardware and software reset
// RL8 - pattern data port at offset 70h loads the pattern table
// RL9 - each pattern mask is four words, low mask bits first, from word 00h
// RL10 - fifth word: crc16 upper half, reserved middle byte, start offset low byte
// RL11 - table holds exactly five patterns, last word at 60h
// RL12 - software loads the full table with 25 consecutive word writes
// RL13 - crc type bit chooses zero or all-ones crc16 preset
// RL14 - five pattern enables, each gates matching of its pattern; reset zero
// RL15 - pattern frame wake enable routes matched enabled frames to power event
// RL16 - data port pointer advances per write, wraps after word 25
// RL17 - match when crc16 over masked bytes from start offset equals stored crc
module wake_event_pattern_ctrl (
    input  wire logic               i_clk,
    input  wire logic               i_srst,
    input  wire logic               i_soft_rst,
    input  wire logic               i_por,
    input  wire logic               i_power_mgmt_config_bit,
    input  wire logic               i_wol_enable,
    input  wire logic               i_csr_wr,
    input  wire logic               i_csr_rd,
    input  wire wake_pkg::csr_addr_t i_csr_addr,
    input  wire wake_pkg::word_t    i_csr_wdata,
    input  wire logic               i_link_up,
    input  wire logic               i_addr_repeat_rx,
    input  wire logic               i_rx_byte_valid,
    input  wire wake_pkg::byte_t    i_rx_byte,
    input  wire logic               i_rx_frame_start,
    input  wire logic               i_rx_frame_end,
    output wake_pkg::word_t         o_csr_rdata,
    output logic [2:0]              o_wake_flags,
    output logic                    o_power_event
);
    import wake_pkg::*;

    wake_state_t st;
    wake_state_t next_st;

    logic [`WAKE_NUM_PATTERNS-1:0] match;
    logic                          ctrl_wr;
    logic                          pdata_wr;
    logic                          link_evt;
    logic                          pat_evt;
    logic [2:0]                    set_v;
    logic [2:0]                    clr_v;

    function automatic logic hit(input csr_addr_t a, input csr_addr_t off);
        return a == off;
    endfunction

    genvar p;
    generate
        for (p = 0; p < `WAKE_NUM_PATTERNS; p++) begin : g_pat
            localparam int B = p * `WAKE_WORDS_PER_PAT;
            wake_pattern_matcher #(
                .MASK_BYTES (`WAKE_MASK_BYTES)
            ) u_match (
                .i_clk          (i_clk),
                .i_srst         (i_srst | i_soft_rst | i_por),
                // see RL9 - lowest word carries mask bits 31:0
                .i_mask         ({st.table_q[B+3], st.table_q[B+2],
                                  st.table_q[B+1], st.table_q[B]}),
                .i_ref_crc      (st.table_q[B+4][`WAKE_FIELD_CRC]),   // see RL10
                .i_start_offset (st.table_q[B+4][`WAKE_FIELD_START]), // see RL10
                .i_preset_sel   (st.crc_sel),
                .i_enable       (st.pat_en[p]),
                .i_byte_valid   (i_rx_byte_valid),
                .i_byte         (i_rx_byte),
                .i_frame_start  (i_rx_frame_start),
                .i_frame_end    (i_rx_frame_end),
                .o_match        (match[p])
            );
        end
    endgenerate

    always_comb begin
        next_st  = st;
        ctrl_wr  = i_csr_wr && hit(i_csr_addr, `WAKE_CTRL_OFFSET);
        pdata_wr = i_csr_wr && hit(i_csr_addr, `WAKE_PDATA_OFFSET);
        // pin is asynchronous to i_clk; only the second and third stages feed logic
        next_st.link_meta = i_link_up;
        next_st.link_sync = st.link_meta;
        next_st.link_prev = st.link_sync;
        link_evt = st.link_sync != st.link_prev;                         // see RL5
        pat_evt  = |(match & st.pat_en);                                 // see RL3
        set_v    = {pat_evt, i_addr_repeat_rx, link_evt};                // see RL4
        clr_v    = ctrl_wr ? i_csr_wdata[`WAKE_FLAGS_FIELD] : 3'h0;
        // set wins over a same-cycle clear so no event is lost
        next_st.flags = (st.flags & ~clr_v) | set_v;                     // see RL6
        next_st.pme = (set_v[`WAKE_BIT_PAT_FLAG] && st.pat_wake_en)     // see RL15
                   || (set_v[`WAKE_BIT_AR_FLAG] && st.ar_wake_en)        // see RL1
                   || (set_v[`WAKE_BIT_LC_FLAG] && st.lc_wake_en);       // see RL2
        if (ctrl_wr) begin
            next_st.crc_sel     = i_csr_wdata[`WAKE_BIT_CRC_SEL];         // see RL13
            for (int i = 0; i < `WAKE_NUM_PATTERNS; i++) begin
                next_st.pat_en[i] = i_csr_wdata[`WAKE_BIT_PAT1_EN - i];  // see RL14
            end
            next_st.pat_wake_en = i_csr_wdata[`WAKE_BIT_PAT_WAKE_EN];
            next_st.ar_wake_en  = i_csr_wdata[`WAKE_BIT_AR_WAKE_EN];
            next_st.lc_wake_en  = i_csr_wdata[`WAKE_BIT_LC_WAKE_EN];
        end
        if (pdata_wr) begin
            next_st.table_q[st.ptr] = i_csr_wdata;                        // see RL8
            // 25 words, then back to pattern one mask word 0
            if (st.ptr == `WAKE_PTR_LAST) begin                           // see RL11
                next_st.ptr = '0;                                         // see RL16
            end else begin
                next_st.ptr = st.ptr + 1'b1;                              // see RL12
            end
        end
        if (i_csr_rd) begin
            next_st.rdata = '0;
            if (hit(i_csr_addr, `WAKE_CTRL_OFFSET)) begin
                next_st.rdata[`WAKE_BIT_CRC_SEL]     = st.crc_sel;
                for (int i = 0; i < `WAKE_NUM_PATTERNS; i++) begin
                    next_st.rdata[`WAKE_BIT_PAT1_EN - i] = st.pat_en[i];
                end
                next_st.rdata[`WAKE_BIT_PAT_WAKE_EN] = st.pat_wake_en;
                next_st.rdata[`WAKE_BIT_AR_WAKE_EN]  = st.ar_wake_en;
                next_st.rdata[`WAKE_BIT_LC_WAKE_EN]  = st.lc_wake_en;
                next_st.rdata[`WAKE_FLAGS_FIELD]     = st.flags;
            end else if (hit(i_csr_addr, `WAKE_PDATA_OFFSET)) begin
                next_st.rdata = st.table_q[st.ptr];
            end
        end
        // flags survive hardware and software reset; only power-up clears them
        if (i_srst || i_soft_rst || i_por) begin                         // see RL7
            next_st.crc_sel     = 1'b0;
            next_st.pat_en      = '0;
            next_st.pat_wake_en = 1'b0;
            next_st.ar_wake_en  = i_power_mgmt_config_bit & i_wol_enable; // see RL1
            next_st.lc_wake_en  = 1'b0;                                   // see RL2
            next_st.table_q     = '0;
            next_st.ptr         = '0;
            next_st.rdata       = '0;
            next_st.pme         = 1'b0;
        end
        if (i_por) begin
            next_st.flags = 3'h0;                                         // see RL6
        end
    end

    always_ff @(posedge i_clk) begin
        st <= next_st;
    end

    assign o_csr_rdata   = st.rdata;
    assign o_wake_flags  = st.flags;
    assign o_power_event = st.pme;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_por);

    logic any_rst;
    assign any_rst = i_srst || i_soft_rst || i_por;

    sequence seq_pdata_write;
        i_csr_wr && hit(i_csr_addr, `WAKE_PDATA_OFFSET) && !any_rst;
    endsequence

    sequence seq_last_word;
        st.ptr == `WAKE_PTR_LAST;
    endsequence

    chk_ar_wake_pme: assert property ( // see RL1
        (i_addr_repeat_rx && st.ar_wake_en && !any_rst) |=> o_power_event)
        else $error("address-repeat wake did not raise power event");

    chk_lc_wake_pme: assert property ( // see RL2
        (link_evt && st.lc_wake_en && !any_rst) |=> o_power_event)
        else $error("link change wake did not raise power event");

    chk_pat_flag_set: assert property ( // see RL3
        pat_evt |=> o_wake_flags[`WAKE_BIT_PAT_FLAG])
        else $error("pattern match did not set flag");

    chk_ar_flag_set: assert property ( // see RL4
        i_addr_repeat_rx |=> o_wake_flags[`WAKE_BIT_AR_FLAG])
        else $error("address-repeat frame did not set flag");

    chk_lc_flag_set: assert property ( // see RL5
        link_evt |=> o_wake_flags[`WAKE_BIT_LC_FLAG])
        else $error("link change did not set flag");

    chk_flag_w1c_only: assert property ( // see RL6
        (st.flags[0] && !(ctrl_wr && i_csr_wdata[0])) |=> st.flags[0])
        else $error("link flag cleared without write one");

    chk_flags_keep_reset: assert property ( // see RL7
        (i_srst || i_soft_rst) |=> ((st.flags & $past(st.flags)) == $past(st.flags)))
        else $error("flags lost over hardware or software reset");

    chk_table_load: assert property ( // see RL8
        seq_pdata_write |=> st.table_q[$past(st.ptr)] == $past(i_csr_wdata))
        else $error("data port write not stored at pointer");

    chk_ptr_wrap: assert property ( // see RL16
        (seq_pdata_write and seq_last_word) |=> st.ptr == '0)
        else $error("pointer did not wrap after last word");

    chk_pme_cause: assert property ( // see RL15
        o_power_event |-> $past(pat_evt && st.pat_wake_en
                               || i_addr_repeat_rx && st.ar_wake_en
                               || link_evt && st.lc_wake_en))
        else $error("power event without enabled cause");
endmodule

// >>> verif/wake_host_model.sv
`timescale 1ns/1ps
module wake_host_model (
    input  wire logic           i_clk,
    output logic                o_csr_wr,
    output logic                o_csr_rd,
    output wake_pkg::csr_addr_t o_csr_addr,
    output wake_pkg::word_t     o_csr_wdata
);
    import wake_pkg::*;
    initial begin
        o_csr_wr = 1'b0;
        o_csr_rd = 1'b0;
        o_csr_addr = 8'h00;
        o_csr_wdata = 32'h00000000;
    end
    // idle data is inverted so a stale word never looks valid
    task automatic wr(input csr_addr_t a, input word_t d);
        @(posedge i_clk);
        o_csr_wr <= 1'b1;
        o_csr_addr <= a;
        o_csr_wdata <= d;
        @(posedge i_clk);
        o_csr_wr <= 1'b0;
        o_csr_wdata <= ~d;
    endtask
    task automatic rd(input csr_addr_t a);
        @(posedge i_clk);
        o_csr_rd <= 1'b1;
        o_csr_addr <= a;
        @(posedge i_clk);
        o_csr_rd <= 1'b0;
    endtask
    // whole filter in one run of consecutive data-port writes
    task automatic load_table(input word_t tbl[25]);
        for (int i = 0; i < 25; i++) begin
            wr(8'h70, tbl[i]);
        end
    endtask
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
    import wake_pkg::*;
    logic i_clk = 1'b0, i_srst, i_soft_rst, i_por, i_power_mgmt_config_bit, i_wol_enable;
    logic i_csr_wr, i_csr_rd, i_link_up, i_addr_repeat_rx;
    logic i_rx_byte_valid, i_rx_frame_start, i_rx_frame_end;
    csr_addr_t i_csr_addr;
    word_t i_csr_wdata, o_csr_rdata;
    byte_t i_rx_byte;
    logic [2:0] o_wake_flags;
    logic o_power_event, rd_pend = 1'b0;
    int error_cnt = 0, comparisons = 0, pev_cnt = 0, pev0;
    integer seed = 32'hEFA2;
    word_t exp_q[$], tbl[25], exp_w;
    word_t cases[6] = '{32'h20000400, 32'h10000400, 32'h50000400, 32'h00000400, 32'h20000000,
                        32'h02000400};
    logic hits[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    byte_t frame[8];
    crc_t crc0, crc1;

    wake_event_pattern_ctrl dut (.i_clk(i_clk), .i_srst(i_srst), .i_soft_rst(i_soft_rst),
        .i_por(i_por), .i_power_mgmt_config_bit(i_power_mgmt_config_bit),
        .i_wol_enable(i_wol_enable),
        .i_csr_wr(i_csr_wr), .i_csr_rd(i_csr_rd), .i_csr_addr(i_csr_addr),
        .i_csr_wdata(i_csr_wdata), .i_link_up(i_link_up), .i_addr_repeat_rx(i_addr_repeat_rx),
        .i_rx_byte_valid(i_rx_byte_valid), .i_rx_byte(i_rx_byte),
        .i_rx_frame_start(i_rx_frame_start), .i_rx_frame_end(i_rx_frame_end),
        .o_csr_rdata(o_csr_rdata), .o_wake_flags(o_wake_flags), .o_power_event(o_power_event));
    wake_host_model host (.i_clk(i_clk), .o_csr_wr(i_csr_wr), .o_csr_rd(i_csr_rd),
        .o_csr_addr(i_csr_addr), .o_csr_wdata(i_csr_wdata));

    always #25 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_power_event === 1'b1) pev_cnt <= pev_cnt + 1;
    // read data lands one edge after the read strobe is taken
    always @(negedge i_clk) begin
        if (rd_pend) begin
            exp_w = exp_q.pop_front();
            `CHECK_EQ(o_csr_rdata, exp_w)
        end
        rd_pend = (i_csr_rd === 1'b1);
    end

    task automatic complete_run();
        if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic rd_chk(input csr_addr_t a, input word_t e);
        exp_q.push_back(e);
        host.rd(a);
        @(posedge i_clk);
    endtask
    task automatic pulse_ar();
        @(posedge i_clk) i_addr_repeat_rx <= 1'b1;
        @(posedge i_clk) i_addr_repeat_rx <= 1'b0;
    endtask
    task automatic send_frame();
        for (int i = 0; i < 8; i++) begin
            @(posedge i_clk);
            i_rx_byte_valid <= 1'b1;
            i_rx_byte <= frame[i];
            i_rx_frame_start <= (i == 0);
        end
        @(posedge i_clk);
        i_rx_byte_valid <= 1'b0;
        i_rx_frame_start <= 1'b0;
        i_rx_frame_end <= 1'b1;
        @(posedge i_clk) i_rx_frame_end <= 1'b0;
    endtask
    // msb-first crc over mask bytes 0..3 counted from start offset 2
    function automatic crc_t crc_of(input crc_t c);
        for (int i = 2; i < 6; i++)
            for (int k = 7; k >= 0; k--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ frame[i][k]) ? 16'h8005 : 16'h0000);
        return c;
    endfunction

    initial begin
        repeat (5000) @(posedge i_clk);
        error_cnt++;
        complete_run();
    end

    initial begin
        {i_soft_rst, i_link_up, i_addr_repeat_rx, i_rx_byte_valid} = 4'h0;
        {i_rx_frame_start, i_rx_frame_end, i_rx_byte} = 10'h000;
        {i_srst, i_por, i_power_mgmt_config_bit, i_wol_enable} = 4'hF;
        repeat (6) @(posedge i_clk);
        i_srst <= 1'b0;
        i_por <= 1'b0;
        rd_chk(8'h68, 32'h00000200);
        rd_chk(8'h40, 32'h00000000);
        host.wr(8'h68, 32'hFFFFFFF8);
        rd_chk(8'h68, 32'h7E000700);
        host.wr(8'h68, 32'h00000200);
        pev0 = pev_cnt;
        pulse_ar();
        rd_chk(8'h68, 32'h00000202);
        `CHECK_EQ(pev_cnt - pev0, 1)
        host.wr(8'h68, 32'h00000200);
        rd_chk(8'h68, 32'h00000202);
        host.wr(8'h68, 32'h00000202);
        rd_chk(8'h68, 32'h00000200);
        host.wr(8'h68, 32'h00000100);
        @(posedge i_clk) i_link_up <= 1'b1;
        repeat (6) @(posedge i_clk);
        rd_chk(8'h68, 32'h00000101);
        `CHECK_EQ(pev_cnt - pev0, 2)
        host.wr(8'h68, 32'h00000001);
        foreach (frame[i]) frame[i] = $random(seed);
        crc0 = crc_of(16'h0000);
        crc1 = crc_of(16'hFFFF);
        foreach (tbl[i]) begin
            tbl[i] = $random(seed);
            if (i % 5 == 4) tbl[i][15:8] = 8'h00;
            if (i / 5 == 0 || i / 5 == 1 || i / 5 == 4)
                tbl[i] = (i % 5 == 0) ? 32'h0000000F : 32'h00000000;
        end
        tbl[4] = {crc0, 16'h0002};
        tbl[9] = {crc1, 16'h0002};
        tbl[24] = {crc0, 16'h0002};
        host.load_table(tbl);
        rd_chk(8'h70, tbl[0]);
        for (int i = 0; i < 25; i++) begin
            host.wr(8'h70, tbl[i]);
            rd_chk(8'h70, tbl[(i + 1) % 25]);
        end
        foreach (cases[c]) begin
            host.wr(8'h68, cases[c] | 32'h7);
            pev0 = pev_cnt;
            send_frame();
            repeat (3) @(posedge i_clk);
            rd_chk(8'h68, cases[c] | {hits[c], 2'b00});
            `CHECK_EQ(o_wake_flags, {hits[c], 2'b00})
            `CHECK_EQ(pev_cnt - pev0, hits[c] & cases[c][10])
        end
        host.wr(8'h68, 32'h00000007);
        pulse_ar();
        i_power_mgmt_config_bit <= 1'b0;
        @(posedge i_clk) i_srst <= 1'b1;
        repeat (2) @(posedge i_clk) i_srst <= 1'b0;
        @(posedge i_clk) i_soft_rst <= 1'b1;
        repeat (2) @(posedge i_clk) i_soft_rst <= 1'b0;
        rd_chk(8'h68, 32'h00000002);
        `CHECK_EQ(o_wake_flags, 3'h2)
        @(posedge i_clk) i_por <= 1'b1;
        repeat (2) @(posedge i_clk) i_por <= 1'b0;
        rd_chk(8'h68, 32'h00000000);
        complete_run();
    end
endmodule
